// file: rtl/mrpi_params.svh
`ifndef MRPI_PARAMS_SVH
`define MRPI_PARAMS_SVH

// link clock timing
`define MRPI_MCLK_PERIOD_NS 5
`define MRPI_LINK_PERIOD_NS 40
`define MRPI_HALF_CYCLES ((`MRPI_LINK_PERIOD_NS) / (2 * `MRPI_MCLK_PERIOD_NS))
`define MRPI_DIV_W 4
`define MRPI_DIV_ZERO 4'h0
`define MRPI_DIV_LAST 4'((`MRPI_HALF_CYCLES) - 1)

// nibble and byte fields
`define MRPI_NIBBLE_ZERO 4'h0
`define MRPI_BYTE_ZERO 8'h00
`define MRPI_LO_HI 3
`define MRPI_LO_LO 0
`define MRPI_HI_HI 7
`define MRPI_HI_LO 4

`endif

// file: rtl/mrpi_pkg.sv
package mrpi_pkg;

  typedef struct packed {
    logic rgmii;
    logic phy;
  } mrpi_mode_s;

  typedef struct packed {
    logic transmit_clock;
    logic receive_clock;
    logic [3:0] receive_nibble;
    logic receive_valid_ctl;
    logic receive_error_in;
    logic carrier_sense_in;
    logic collision_in;
  } mrpi_pin_in_s;

  typedef struct packed {
    logic transmit_clock_out;
    logic transmit_clock_oe_n;
    logic receive_clock_out;
    logic receive_clock_oe_n;
    logic [3:0] transmit_nibble;
    logic transmit_enable_ctl;
  } mrpi_pin_out_s;

  typedef struct packed {
    logic valid;
    logic error;
    logic [7:0] data;
  } mrpi_byte_s;

  typedef struct packed {
    logic carrier_sense;
    logic collision;
  } mrpi_line_s;

endpackage

// file: rtl/mrpi_link_clock.sv
`timescale 1ns/1ps
`include "mrpi_params.svh"

module mrpi_link_clock (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_pin,
  input wire logic own,
  output logic clk_out_reg,
  output logic rise,
  output logic fall
);
  logic last_reg;
  logic [`MRPI_DIV_W-1:0] div_reg;
  logic wrap;

  assign wrap = (div_reg == `MRPI_DIV_LAST);

  // divider for a clock this end sources
  always_ff @(posedge mclk) begin
    if (srst || !own) begin
      div_reg <= `MRPI_DIV_ZERO;
      clk_out_reg <= 1'b0;
    end else if (wrap) begin
      div_reg <= `MRPI_DIV_ZERO;
      clk_out_reg <= !clk_out_reg;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // previous level of a clock from the far end
  always_ff @(posedge mclk) begin
    if (srst) begin
      last_reg <= clk_pin; // no false edge after reset
    end else begin
      last_reg <= clk_pin;
    end
  end

  // own clock: edge about to happen; far clock: edge just seen
  always_comb begin
    if (own) begin
      rise = wrap && !clk_out_reg;
      fall = wrap && clk_out_reg;
    end else begin
      rise = clk_pin && !last_reg;
      fall = !clk_pin && last_reg;
    end
  end
endmodule

// file: rtl/mrpi_port_interface.sv
`timescale 1ns/1ps
`include "mrpi_params.svh"

// Summary of operation
// (R1) rgmii tx ctl: enable rising, derived falling
// (R2) far end rgmii rx ctl same scheme
// (R3) tx clock: input mac mii, driven phy mii
// (R4) rx clock: input mac mii, driven phy mii
// (R5) rgmii: tx clock sourced, rx clock input
// (R6) collision used only in mii mac mode
// (R7) carrier sense used only in mii mac mode
// (R8) mii tx enable qualifies each nibble
// (R9) far end mii rx valid qualifies nibbles
// (R10) falling ctl value is flag xor error
module mrpi_port_interface (
  input wire logic mclk,
  input wire logic srst,
  input mrpi_pkg::mrpi_mode_s [1:0] port_mode,
  input mrpi_pkg::mrpi_pin_in_s [1:0] pin_in,
  output mrpi_pkg::mrpi_pin_out_s [1:0] pin_out,
  input mrpi_pkg::mrpi_byte_s [1:0] tx_req,
  output logic [1:0] tx_take,
  output mrpi_pkg::mrpi_byte_s [1:0] rx_word,
  output mrpi_pkg::mrpi_line_s [1:0] line_state
);
  import mrpi_pkg::*;

  function automatic logic ctl_fall(input logic flag, input logic err);
    ctl_fall = flag ^ err;
  endfunction

  function automatic logic [3:0] lo_nibble(input logic [7:0] b);
    lo_nibble = b[`MRPI_LO_HI:`MRPI_LO_LO];
  endfunction

  function automatic logic [3:0] hi_nibble(input logic [7:0] b);
    hi_nibble = b[`MRPI_HI_HI:`MRPI_HI_LO];
  endfunction

  function automatic logic [7:0] join_nibbles(input logic [3:0] hi, input logic [3:0] lo);
    join_nibbles = {hi, lo};
  endfunction

  function automatic logic tx_sourced(input mrpi_mode_s m);
    tx_sourced = m.rgmii || m.phy;
  endfunction

  function automatic logic rx_sourced(input mrpi_mode_s m);
    rx_sourced = !m.rgmii && m.phy;
  endfunction

  function automatic logic mii_mac(input mrpi_mode_s m);
    mii_mac = !m.rgmii && !m.phy;
  endfunction

  genvar p;
  for (p = 0; p < 2; p++) begin : g_port
    logic rgmii;
    logic tx_own;
    logic rx_own;
    logic tx_rise;
    logic tx_fall;
    logic rx_rise;
    logic rx_fall;
    logic txc_reg;
    logic rxc_reg;
    logic txc_oe_n_reg;
    logic rxc_oe_n_reg;
    logic [3:0] tx_nibble_reg;
    logic tx_ctl_reg;
    logic tx_half_reg;
    logic tx_en_reg;
    logic tx_er_reg;
    logic [7:0] tx_byte_reg;
    logic tx_take_reg;
    logic rx_half_reg;
    logic rx_dv_reg;
    logic rx_err_reg;
    logic [3:0] rx_low_reg;
    mrpi_byte_s rx_word_reg;
    mrpi_line_s line_reg;

    assign rgmii = port_mode[p].rgmii;
    assign tx_own = tx_sourced(port_mode[p]); // [R3] [R5]
    assign rx_own = rx_sourced(port_mode[p]); // [R4] [R5]

    mrpi_link_clock u_tx_clock (
      .mclk(mclk),
      .srst(srst),
      .clk_pin(pin_in[p].transmit_clock),
      .own(tx_own),
      .clk_out_reg(txc_reg),
      .rise(tx_rise),
      .fall(tx_fall)
    );

    mrpi_link_clock u_rx_clock (
      .mclk(mclk),
      .srst(srst),
      .clk_pin(pin_in[p].receive_clock),
      .own(rx_own),
      .clk_out_reg(rxc_reg),
      .rise(rx_rise),
      .fall(rx_fall)
    );

    // clock pin direction
    always_ff @(posedge mclk) begin
      if (srst) begin
        txc_oe_n_reg <= 1'b1;
        rxc_oe_n_reg <= 1'b1;
      end else begin
        txc_oe_n_reg <= !tx_own; // [R3] [R5]
        rxc_oe_n_reg <= !rx_own; // [R4] [R5]
      end
    end

    // transmit path
    always_ff @(posedge mclk) begin
      if (srst) begin
        tx_nibble_reg <= `MRPI_NIBBLE_ZERO;
        tx_ctl_reg <= 1'b0;
        tx_half_reg <= 1'b0;
        tx_en_reg <= 1'b0;
        tx_er_reg <= 1'b0;
        tx_byte_reg <= `MRPI_BYTE_ZERO;
        tx_take_reg <= 1'b0;
      end else begin
        tx_take_reg <= 1'b0;
        if (rgmii) begin
          tx_half_reg <= 1'b0;
          if (tx_rise) begin
            tx_en_reg <= tx_req[p].valid;
            tx_er_reg <= tx_req[p].valid && tx_req[p].error;
            tx_ctl_reg <= tx_req[p].valid; // [R1]
            tx_take_reg <= tx_req[p].valid;
            tx_byte_reg <= tx_req[p].data;
            tx_nibble_reg <= tx_req[p].valid ?
              lo_nibble(tx_req[p].data) : `MRPI_NIBBLE_ZERO;
          end else if (tx_fall) begin
            tx_ctl_reg <= ctl_fall(tx_en_reg, tx_er_reg); // [R1] [R10]
            tx_nibble_reg <= tx_en_reg ?
              hi_nibble(tx_byte_reg) : `MRPI_NIBBLE_ZERO;
          end
        end else if (tx_rise) begin
          if (tx_half_reg) begin
            tx_nibble_reg <= hi_nibble(tx_byte_reg); // [R8]
            tx_ctl_reg <= 1'b1; // [R8]
            tx_half_reg <= 1'b0;
          end else if (tx_req[p].valid) begin
            tx_nibble_reg <= lo_nibble(tx_req[p].data); // [R8]
            tx_ctl_reg <= 1'b1; // [R8]
            tx_byte_reg <= tx_req[p].data;
            tx_take_reg <= 1'b1;
            tx_half_reg <= 1'b1;
          end else begin
            tx_nibble_reg <= `MRPI_NIBBLE_ZERO;
            tx_ctl_reg <= 1'b0; // [R8]
          end
        end
      end
    end

    // receive path
    always_ff @(posedge mclk) begin
      if (srst) begin
        rx_half_reg <= 1'b0;
        rx_dv_reg <= 1'b0;
        rx_err_reg <= 1'b0;
        rx_low_reg <= `MRPI_NIBBLE_ZERO;
        rx_word_reg <= '0;
      end else begin
        rx_word_reg.valid <= 1'b0;
        if (rgmii) begin
          rx_half_reg <= 1'b0;
          if (rx_rise) begin
            rx_dv_reg <= pin_in[p].receive_valid_ctl; // [R2]
            rx_low_reg <= pin_in[p].receive_nibble;
          end else if (rx_fall && rx_dv_reg) begin
            rx_word_reg.valid <= 1'b1;
            rx_word_reg.data <= join_nibbles(pin_in[p].receive_nibble, rx_low_reg);
            rx_word_reg.error <= ctl_fall(rx_dv_reg,
              pin_in[p].receive_valid_ctl); // [R2] [R10]
          end
        end else if (rx_rise) begin
          if (!pin_in[p].receive_valid_ctl) begin
            rx_half_reg <= 1'b0; // [R9]
          end else if (!rx_half_reg) begin
            rx_low_reg <= pin_in[p].receive_nibble; // [R9]
            rx_err_reg <= pin_in[p].receive_error_in;
            rx_half_reg <= 1'b1;
          end else begin
            rx_word_reg.valid <= 1'b1; // [R9]
            rx_word_reg.data <= join_nibbles(pin_in[p].receive_nibble, rx_low_reg);
            rx_word_reg.error <= rx_err_reg || pin_in[p].receive_error_in;
            rx_half_reg <= 1'b0;
          end
        end
      end
    end

    // carrier sense and collision
    always_ff @(posedge mclk) begin
      if (srst) begin
        line_reg <= '0;
      end else if (mii_mac(port_mode[p])) begin
        line_reg.carrier_sense <= pin_in[p].carrier_sense_in; // [R7]
        line_reg.collision <= pin_in[p].collision_in; // [R6]
      end else begin
        line_reg <= '0; // [R6] [R7]
      end
    end

    assign pin_out[p].transmit_clock_out = txc_reg;
    assign pin_out[p].transmit_clock_oe_n = txc_oe_n_reg;
    assign pin_out[p].receive_clock_out = rxc_reg;
    assign pin_out[p].receive_clock_oe_n = rxc_oe_n_reg;
    assign pin_out[p].transmit_nibble = tx_nibble_reg;
    assign pin_out[p].transmit_enable_ctl = tx_ctl_reg;
    assign tx_take[p] = tx_take_reg;
    assign rx_word[p] = rx_word_reg;
    assign line_state[p] = line_reg;
  end
endmodule

// file: verification/mrpi_port_interface_asserts.sv
`timescale 1ns/1ps
module mrpi_chk (
  input wire logic mclk,
  input wire logic srst,
  input mrpi_pkg::mrpi_mode_s [1:0] port_mode,
  input mrpi_pkg::mrpi_pin_in_s [1:0] pin_in,
  input mrpi_pkg::mrpi_pin_out_s [1:0] pin_out,
  input mrpi_pkg::mrpi_byte_s [1:0] tx_req,
  input wire logic [1:0] tx_take,
  input mrpi_pkg::mrpi_byte_s [1:0] rx_word,
  input mrpi_pkg::mrpi_line_s [1:0] line_state
);
  import mrpi_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  tx_oe_a: assert property (!$past(srst) |->
    pin_out[1].transmit_clock_oe_n == !(port_mode[1].rgmii | port_mode[1].phy)) else $error("txc oe");
  rx_oe_a: assert property (!$past(srst) |-> pin_out[0].receive_clock_oe_n &&
    pin_out[1].receive_clock_oe_n == !(port_mode[1].phy && !port_mode[1].rgmii)) else $error("rxc oe");
  lines_off_a: assert property (!$past(srst) && port_mode[0].rgmii |->
    line_state[0] == 2'b00) else $error("lines used");
  lines_mac_a: assert property (!$past(srst) && !port_mode[1].rgmii && !port_mode[1].phy |->
    line_state[1] == {$past(pin_in[1].carrier_sense_in), $past(pin_in[1].collision_in)})
    else $error("lines lost");
  tx_take_a: assert property (tx_take[0] |->
    $past(tx_req[0].valid) && $rose(pin_out[0].transmit_clock_out)) else $error("bad take");
  ctl_rise_a: assert property ($rose(pin_out[0].transmit_clock_out) |->
    pin_out[0].transmit_enable_ctl == tx_take[0] && (!tx_take[0] ||
    pin_out[0].transmit_nibble == $past(tx_req[0].data[3:0]))) else $error("rise ctl");
  ctl_fall_a: assert property ($past(tx_take[0], 4) && $fell(pin_out[0].transmit_clock_out) |->
    pin_out[0].transmit_enable_ctl == ($past(tx_req[0].valid, 5) ^ $past(tx_req[0].error, 5))
    && pin_out[0].transmit_nibble == $past(tx_req[0].data[7:4], 5)) else $error("fall ctl");
  half_per_a: assert property ($rose(pin_out[0].transmit_clock_out) |->
    pin_out[0].transmit_clock_out[*4] ##1 !pin_out[0].transmit_clock_out) else $error("txc period");
  take_c: cover property (tx_take[0]);
  rxw_c: cover property (rx_word[1].valid);
  col_c: cover property (line_state[1].collision);
endmodule
bind mrpi_port_interface mrpi_chk chk_u (.mclk(mclk), .srst(srst), .port_mode(port_mode),
  .pin_in(pin_in), .pin_out(pin_out), .tx_req(tx_req), .tx_take(tx_take), .rx_word(rx_word),
  .line_state(line_state));

// file: verification/mrpi_far_end.sv
`timescale 1ns/1ps
module mrpi_far_end (
  input wire logic mclk,
  input wire logic rgmii,
  input wire logic go,
  input wire logic [8:0] frame,
  output logic rxc,
  output logic [3:0] nib,
  output logic ctl,
  output logic er,
  output logic busy
);
  task automatic half(input logic c, input logic [3:0] n, input logic k);
    nib = n;
    ctl = k;
    @(negedge mclk);
    rxc = c;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    {rxc, nib, ctl, er, busy} = '0;
  end
  always @(negedge mclk) begin
    if (go && !busy) begin
      busy = 1'b1;
      er = frame[8] & !rgmii;
      half(1'b1, frame[3:0], 1'b1);
      if (rgmii) begin
        half(1'b0, frame[7:4], !frame[8]);
      end else begin
        half(1'b0, frame[3:0], 1'b1);
        half(1'b1, frame[7:4], 1'b1);
        half(1'b0, frame[7:4], 1'b1);
        half(1'b1, ~frame[7:4], 1'b0);
      end
      half(1'b0, ~nib, 1'b0);
      er = 1'b0;
      busy = 1'b0;
    end
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mrpi_pkg::*;
  logic mclk = 0, srst = 1, tck = 0, run = 0, crs = 0, col = 0;
  logic [1:0] go = '0, tx_take, rxc, ctl, er, busy;
  logic [1:0][3:0] nib;
  logic [8:0] frm = '0;
  mrpi_mode_s [1:0] mode = {2'b00, 2'b10};
  mrpi_pin_in_s [1:0] pin_in;
  mrpi_pin_out_s [1:0] pin_out;
  mrpi_byte_s [1:0] tx_req = '0, rx_word;
  mrpi_line_s [1:0] line_state;
  int err_total = 0, cmp_count = 0, n;
  always #2.5 mclk = ~mclk;
  always begin
    repeat (4) @(negedge mclk);
    if (run) tck = ~tck;
  end
  for (genvar p = 0; p < 2; p++) begin : g_far
    mrpi_far_end far_u (.mclk(mclk), .rgmii(mode[p].rgmii), .go(go[p]), .frame(frm),
      .rxc(rxc[p]), .nib(nib[p]), .ctl(ctl[p]), .er(er[p]), .busy(busy[p]));
    assign pin_in[p] = {tck, rxc[p], nib[p], ctl[p], er[p], crs, col};
  end
  mrpi_port_interface dut_u (.mclk(mclk), .srst(srst), .port_mode(mode), .pin_in(pin_in),
    .pin_out(pin_out), .tx_req(tx_req), .tx_take(tx_take), .rx_word(rx_word),
    .line_state(line_state));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tmo();
    if (n >= 99) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic do_reset(input logic phy1);
    srst = 1;
    mode[1].phy = phy1;
    repeat (12) @(negedge mclk);
    srst = 0;
    @(negedge mclk);
    chk({5'h0, pin_out[0].transmit_clock_oe_n, pin_out[0].receive_clock_oe_n,
      pin_out[1].transmit_clock_oe_n, pin_out[1].receive_clock_oe_n}, phy1 ? 9'h4 : 9'h7);
  endtask
  task automatic sc_rgmii_tx();
    mrpi_byte_s b;
    tx_req[0] = {1'b1, 1'b0, 8'h5a};
    for (int i = 0; i < 2; i++) begin
      for (n = 0; n < 99 && tx_take[0] !== 1'b1; n++) @(negedge mclk);
      tmo();
      chk({pin_out[0].transmit_enable_ctl, 4'h0, pin_out[0].transmit_nibble}, {5'h10, tx_req[0].data[3:0]});
      b = tx_req[0];
      tx_req[0] = {!i[0], !i[0], 8'h96};
      for (n = 0; n < 99 && pin_out[0].transmit_clock_out !== 1'b0; n++) @(negedge mclk);
      tmo();
      chk({pin_out[0].transmit_enable_ctl, 4'h0, pin_out[0].transmit_nibble}, {b.valid ^ b.error, 4'h0, b.data[7:4]});
    end
  endtask
  task automatic sc_mii_tx();
    run = 1;
    tx_req[1] = {1'b1, 1'b0, 8'ha5};
    for (n = 0; n < 99 && tx_take[1] !== 1'b1; n++) @(negedge mclk);
    tmo();
    tx_req[1] = '0;
    chk({pin_out[1].transmit_enable_ctl, 4'h0, pin_out[1].transmit_nibble}, 9'h105);
    for (n = 0; n < 99 && pin_out[1].transmit_nibble === 4'h5; n++) @(negedge mclk);
    tmo();
    chk({pin_out[1].transmit_enable_ctl, 4'h0, pin_out[1].transmit_nibble}, 9'h10a);
    for (n = 0; n < 99 && pin_out[1].transmit_enable_ctl !== 1'b0; n++) @(negedge mclk);
    tmo();
    chk({pin_out[1].transmit_enable_ctl, 4'h0, pin_out[1].transmit_nibble}, 9'h000);
    run = 0;
  endtask
  task automatic sc_rx(input int p, input logic [8:0] f);
    for (n = 0; n < 99 && busy[p] !== 1'b0; n++) @(negedge mclk);
    tmo();
    frm = f;
    go[p] = 1;
    for (n = 0; n < 99 && rx_word[p].valid !== 1'b1; n++) @(negedge mclk);
    tmo();
    go[p] = 0;
    chk({rx_word[p].error, rx_word[p].data}, f);
  endtask
  task automatic sc_lines();
    crs = 1;
    repeat (3) @(negedge mclk);
    chk({line_state[1], line_state[0], 5'h0}, 9'h100);
    {crs, col} = 2'b01;
    repeat (3) @(negedge mclk);
    chk({line_state[1], line_state[0], 5'h0}, 9'h080);
  endtask
  initial begin
    do_reset(0);
    sc_rgmii_tx();
    sc_mii_tx();
    sc_rx(0, 9'h13c);
    sc_rx(0, 9'h0c3);
    sc_rx(1, 9'h1c3);
    sc_rx(1, 9'h03c);
    sc_lines();
    do_reset(1);
    for (n = 0; n < 99 && pin_out[1].receive_clock_out !== 1'b1; n++) @(negedge mclk);
    tmo();
    chk({5'h0, pin_out[1].transmit_clock_out, pin_out[1].receive_clock_out, line_state[1]},
      9'h00c);
    wrap_up();
  end
endmodule
